// ---- verilog/lmef_pkg.sv ----
package lmef_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ERR_WORD_OFS = 8'h00;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h04;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h08;
    localparam logic [7:0] PANEL_OFS = 8'h0c;

    localparam logic [15:0] ERR_WORD_RST = 16'h0000;
    localparam logic [5:0] IRQ_STAT_RST = 6'h00;
    localparam logic [5:0] IRQ_MASK_RST = 6'h00;

    // ------------------------------------------------------------
    // Error word bit positions
    // ------------------------------------------------------------
    localparam int ERR_RATE_BIT = 4;
    localparam int ERR_STN_BIT = 6;
    localparam int ERR_EEP_BIT = 7;
    localparam int ERR_SW_BIT = 8;
    localparam int ERR_HW_BIT = 15;

    // Interrupt status bit positions
    localparam int IRQ_RATE_BIT = 0;
    localparam int IRQ_STN_BIT = 1;
    localparam int IRQ_EEP_BIT = 2;
    localparam int IRQ_SW_BIT = 3;
    localparam int IRQ_HW_BIT = 4;
    localparam int IRQ_ARM_BIT = 5;

    // ------------------------------------------------------------
    // Switch and station limits
    // ------------------------------------------------------------
    localparam logic [3:0] RATE_VALID_MASK = 4'h7;
    localparam logic [6:0] RD_STN_MIN = 7'd49;
    localparam logic [6:0] RD_STN_MAX = 7'd64;

    // Panel menu cursor positions
    localparam logic [1:0] MAIN_NET_ITEM = 2'h1;
    localparam logic [1:0] SET_SELFCHK_ITEM = 2'h2;
    localparam logic [1:0] CURSOR_MAX = 2'h3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int CONFIRM_TIME_MS = 500;
    localparam int CONFIRM_CYC = CONFIRM_TIME_MS * (CLK_HZ / 1000);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] rate;
        logic four_pt;
        logic [1:0] op_mode;
    } lmef_sw_t;

    typedef struct packed {
        logic ok;
        logic esc;
        logic plus;
        logic minus;
    } lmef_keys_t;

    typedef enum logic [2:0] {
        SCR_MAIN = 3'b000,
        SCR_CONFIRM = 3'b001,
        SCR_SETTINGS = 3'b010,
        SCR_SC_START = 3'b011,
        SCR_SC_DONE = 3'b100,
        SCR_SC_FAIL = 3'b101
    } lmef_screen_t;

endpackage

// ---- verilog/lmef_top.sv ----
`timescale 1ns/1ns

module lmef_top #(
    parameter int CONFIRM_CYCLES = lmef_pkg::CONFIRM_CYC
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire lmef_pkg::lmef_sw_t SW,
    input wire logic CONFIG_MODE,
    input wire logic EEP_REQ,
    input wire logic RD_STN_VALID,
    input wire logic [6:0] RD_STN_NUM,
    input wire logic LOOPBACK_FAULT,
    input wire lmef_pkg::lmef_keys_t KEYS,
    input wire logic ARM_READY,
    input wire logic ARM_STORED,
    input wire logic [7:0] ADDR,
    input wire logic [15:0] WR_DATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [15:0] RD_DATA,
    output logic IRQ,
    output lmef_pkg::lmef_screen_t SCREEN,
    output logic ARM_STORE,
    output logic SELFCHK_RUN
);

    // ------------------------------------------------------------
    // Power-on capture
    // ------------------------------------------------------------
    logic boot_done_r;
    lmef_pkg::lmef_sw_t sw_boot_r;
    logic selfchk_run_r;

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            boot_done_r <= 1'b0;
            sw_boot_r <= '0;
            selfchk_run_r <= 1'b0;
        end else if (!boot_done_r) begin
            boot_done_r <= 1'b1;
            sw_boot_r <= SW;
            selfchk_run_r <= ARM_STORED;
        end
    end

    // ------------------------------------------------------------
    // Error conditions
    // ------------------------------------------------------------
    wire rate_bad = !lmef_pkg::RATE_VALID_MASK[SW.rate];
    wire stn_out_of_range = RD_STN_VALID &&
        (RD_STN_NUM < lmef_pkg::RD_STN_MIN || RD_STN_NUM > lmef_pkg::RD_STN_MAX);
    wire stn_in_four_pt = RD_STN_VALID && SW.four_pt;
    wire eep_bad = EEP_REQ && !CONFIG_MODE;
    wire sw_changed = boot_done_r && (SW != sw_boot_r);

    logic rate_err_r;
    logic stn_err_r;
    logic eep_err_r;
    logic sw_err_r;
    logic hw_err_r;
    logic eep_err_nxt;

    // Held while the offending request stays up, dropped when it is withdrawn
    assign eep_err_nxt = EEP_REQ && (eep_err_r || eep_bad);

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            rate_err_r <= 1'b0;
            stn_err_r <= 1'b0;
            eep_err_r <= 1'b0;
            sw_err_r <= 1'b0;
            hw_err_r <= 1'b0;
        end else begin
            rate_err_r <= rate_err_r || rate_bad;
            stn_err_r <= stn_err_r || stn_out_of_range || stn_in_four_pt;
            eep_err_r <= eep_err_nxt;
            sw_err_r <= sw_changed;
            hw_err_r <= hw_err_r || LOOPBACK_FAULT;
        end
    end

    logic [15:0] err_word;

    // Reserved positions stay zero
    always_comb begin
        err_word = lmef_pkg::ERR_WORD_RST;
        err_word[lmef_pkg::ERR_RATE_BIT] = rate_err_r;
        err_word[lmef_pkg::ERR_STN_BIT] = stn_err_r;
        err_word[lmef_pkg::ERR_EEP_BIT] = eep_err_r;
        err_word[lmef_pkg::ERR_SW_BIT] = sw_err_r;
        err_word[lmef_pkg::ERR_HW_BIT] = hw_err_r;
    end

    // ------------------------------------------------------------
    // Operator panel
    // ------------------------------------------------------------
    lmef_pkg::lmef_screen_t scr_r;
    lmef_pkg::lmef_screen_t scr_nxt;
    logic [1:0] cursor_r;
    logic [1:0] cursor_nxt;
    logic [25:0] confirm_cnt_r;
    logic arm_r;
    logic arm_done_pulse;

    wire confirm_over = confirm_cnt_r == 26'(CONFIRM_CYCLES - 1);
    wire cur_up = KEYS.plus && cursor_r != lmef_pkg::CURSOR_MAX;
    wire cur_dn = KEYS.minus && cursor_r != 2'h0;
    wire [1:0] cursor_moved = cur_up ? cursor_r + 2'h1 :
        cur_dn ? cursor_r - 2'h1 : cursor_r;

    always_comb begin
        scr_nxt = scr_r;
        cursor_nxt = cursor_r;
        arm_done_pulse = 1'b0;
        case (scr_r)
            lmef_pkg::SCR_MAIN: begin
                cursor_nxt = cursor_moved;
                if (KEYS.ok && cursor_r == lmef_pkg::MAIN_NET_ITEM) begin
                    scr_nxt = lmef_pkg::SCR_CONFIRM;
                end
            end
            lmef_pkg::SCR_CONFIRM: begin
                if (confirm_over) begin
                    scr_nxt = lmef_pkg::SCR_SETTINGS;
                    cursor_nxt = 2'h0;
                end
            end
            lmef_pkg::SCR_SETTINGS: begin
                cursor_nxt = cursor_moved;
                if (KEYS.esc) begin
                    scr_nxt = lmef_pkg::SCR_MAIN;
                    cursor_nxt = 2'h0;
                end else if (KEYS.ok && cursor_r == lmef_pkg::SET_SELFCHK_ITEM) begin
                    scr_nxt = lmef_pkg::SCR_SC_START;
                end
            end
            lmef_pkg::SCR_SC_START: begin
                if (KEYS.esc) begin
                    scr_nxt = lmef_pkg::SCR_SETTINGS;
                end else if (KEYS.ok) begin
                    arm_done_pulse = ARM_READY;
                    scr_nxt = ARM_READY ? lmef_pkg::SCR_SC_DONE : lmef_pkg::SCR_SC_FAIL;
                end
            end
            lmef_pkg::SCR_SC_DONE,
            lmef_pkg::SCR_SC_FAIL: begin
                if (KEYS.esc) begin
                    scr_nxt = lmef_pkg::SCR_SETTINGS;
                end else if (KEYS.ok) begin
                    scr_nxt = lmef_pkg::SCR_MAIN;
                    cursor_nxt = 2'h0;
                end
            end
            default: begin
                scr_nxt = lmef_pkg::SCR_MAIN;
                cursor_nxt = 2'h0;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            scr_r <= lmef_pkg::SCR_MAIN;
            cursor_r <= 2'h0;
        end else begin
            scr_r <= scr_nxt;
            cursor_r <= cursor_nxt;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || scr_r != lmef_pkg::SCR_CONFIRM) begin
            confirm_cnt_r <= 26'h0;
        end else begin
            confirm_cnt_r <= confirm_cnt_r + 26'h1;
        end
    end

    // Arming is only remembered; the test itself waits for the next power-up
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            arm_r <= 1'b0;
        end else if (arm_done_pulse) begin
            arm_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    logic [5:0] irq_stat_r;
    logic [5:0] irq_mask_r;
    logic [5:0] ev_now;
    logic [5:0] ev_prev_r;

    assign ev_now = {arm_r, hw_err_r, sw_err_r, eep_err_r, stn_err_r, rate_err_r};
    wire [5:0] ev_rise = ev_now & ~ev_prev_r;
    wire wr_stat = WR_EN && ADDR == lmef_pkg::IRQ_STAT_OFS;
    wire wr_mask = WR_EN && ADDR == lmef_pkg::IRQ_MASK_OFS;
    wire [5:0] stat_clr = wr_stat ? WR_DATA[5:0] : 6'h00;
    // A new event in the clear cycle survives the clear
    wire [5:0] irq_stat_nxt = (irq_stat_r & ~stat_clr) | ev_rise;

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            ev_prev_r <= 6'h00;
            irq_stat_r <= lmef_pkg::IRQ_STAT_RST;
            irq_mask_r <= lmef_pkg::IRQ_MASK_RST;
            IRQ <= 1'b0;
        end else begin
            ev_prev_r <= ev_now;
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= wr_mask ? WR_DATA[5:0] : irq_mask_r;
            IRQ <= |(irq_stat_nxt & (wr_mask ? WR_DATA[5:0] : irq_mask_r));
        end
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    logic [15:0] rd_mux;

    always_comb begin
        case (ADDR)
            lmef_pkg::ERR_WORD_OFS: rd_mux = err_word;
            lmef_pkg::IRQ_STAT_OFS: rd_mux = {10'h000, irq_stat_r};
            lmef_pkg::IRQ_MASK_OFS: rd_mux = {10'h000, irq_mask_r};
            lmef_pkg::PANEL_OFS: rd_mux = {9'h000, selfchk_run_r, arm_r, cursor_r, scr_r};
            default: rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            RD_DATA <= 16'h0000;
            SCREEN <= lmef_pkg::SCR_MAIN;
            ARM_STORE <= 1'b0;
            SELFCHK_RUN <= 1'b0;
        end else begin
            RD_DATA <= RD_EN ? rd_mux : 16'h0000;
            SCREEN <= scr_nxt;
            ARM_STORE <= arm_r;
            SELFCHK_RUN <= selfchk_run_r;
        end
    end

endmodule

// ---- verif/lmef_chk_sva.sv ----
`timescale 1ns/1ns
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module lmef_chk #(
    parameter int CONFIRM_CYCLES = 8
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic EEP_REQ,
    input wire logic CONFIG_MODE,
    input wire lmef_pkg::lmef_keys_t KEYS,
    input wire logic ARM_READY,
    input wire logic [7:0] ADDR,
    input wire logic RD_EN,
    input wire logic [15:0] RD_DATA,
    input wire lmef_pkg::lmef_screen_t SCREEN,
    input wire logic ARM_STORE
);
    logic [15:0] seen_r;
    logic [31:0] cnt_r;
    logic rd0_r;
    // Sticky flags once read as set must keep reading set
    always_ff @(posedge SYS_CLK) begin
        rd0_r <= RST_N && RD_EN && ADDR == 8'h00;
        cnt_r <= (SCREEN == lmef_pkg::SCR_CONFIRM) ? cnt_r + 32'd1 : 32'd0;
        if (!RST_N) begin
            seen_r <= 16'h0000;
        end else if (rd0_r) begin
            seen_r <= seen_r | (RD_DATA & 16'h8050);
        end
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    rsv_zero_a: assert property (rd0_r |-> (RD_DATA & 16'h7e2f) == 16'h0000)
        else $error("reserved bits set");
    sticky_flag_a: assert property (rd0_r |-> (RD_DATA & seen_r) == seen_r)
        else $error("sticky flag lost");
    eep_set_a: assert property (rd0_r && $past(EEP_REQ, 2) && !$past(CONFIG_MODE, 2)
        && $past(EEP_REQ) |-> RD_DATA[7]) else $error("eeprom flag missing");
    eep_clr_a: assert property (rd0_r && !$past(EEP_REQ, 2) && !$past(EEP_REQ)
        |-> !RD_DATA[7]) else $error("eeprom flag stuck");
    confirm_len_a: assert property ($past(SCREEN) == lmef_pkg::SCR_CONFIRM
        && SCREEN != lmef_pkg::SCR_CONFIRM |-> SCREEN == lmef_pkg::SCR_SETTINGS
        && cnt_r == CONFIRM_CYCLES) else $error("confirm screen length wrong");
    sc_hold_a: assert property ($past(SCREEN) == lmef_pkg::SCR_SC_START
        && ($past(KEYS.plus) || $past(KEYS.minus)) |-> SCREEN == lmef_pkg::SCR_SC_START)
        else $error("plus or minus acted");
    sc_ok_a: assert property ($past(SCREEN) == lmef_pkg::SCR_SC_START && $past(KEYS.ok)
        |-> SCREEN == ($past(ARM_READY) ? lmef_pkg::SCR_SC_DONE : lmef_pkg::SCR_SC_FAIL))
        else $error("arming result wrong");
    arm_store_a: assert property ($rose(ARM_STORE) |-> $past(SCREEN) == lmef_pkg::SCR_SC_DONE)
        else $error("arm stored without success");
endmodule

bind lmef_top lmef_chk #(.CONFIRM_CYCLES(CONFIRM_CYCLES)) u_lmef_chk (.SYS_CLK, .RST_N,
    .EEP_REQ, .CONFIG_MODE, .KEYS, .ARM_READY, .ADDR, .RD_EN, .RD_DATA, .SCREEN, .ARM_STORE);

// ---- verif/lmef_stn_model.sv ----
`timescale 1ns/1ns
// ------------------------------------------------------------
// Remote station on the field network
// ------------------------------------------------------------
module lmef_stn_model (
    input wire logic clk,
    output logic vld,
    output logic [6:0] num
);
    initial begin
        vld = 1'b0;
        num = 7'h00;
    end
    task automatic attach(input logic [6:0] n);
        @(posedge clk);
        vld <= 1'b1;
        num <= n;
    endtask
    // Released number lines show the inverse, never a stale number
    task automatic detach();
        @(posedge clk);
        vld <= 1'b0;
        num <= ~num;
    endtask
endmodule

// ---- verif/tb_link_master_error_flags.sv ----
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("BAD %0t %h %h", $time, a, e); end end
// ------------------------------------------------------------
// Testbench
// ------------------------------------------------------------
module tb_link_master_error_flags;
    logic SYS_CLK = 1'b0, RST_N = 1'b0, CONFIG_MODE = 1'b0, EEP_REQ = 1'b0;
    logic LOOPBACK_FAULT = 1'b0, ARM_READY = 1'b0, ARM_STORED = 1'b0, WR_EN = 1'b0;
    logic RD_EN = 1'b0, IRQ, ARM_STORE, SELFCHK_RUN, stn_vld;
    lmef_pkg::lmef_sw_t SW = '0;
    lmef_pkg::lmef_keys_t KEYS = '0;
    lmef_pkg::lmef_screen_t SCREEN;
    logic [7:0] ADDR = 8'h00;
    logic [15:0] WR_DATA = 16'h0000, RD_DATA;
    logic [6:0] stn_num;
    logic [6:0] nums [5] = '{7'h30, 7'h31, 7'h40, 7'h41, 7'h32};
    logic [15:0] exps [5] = '{16'h0040, 16'h0000, 16'h0000, 16'h0040, 16'h0040};
    int error_cnt = 0, n_checks = 0;
    lmef_top #(.CONFIRM_CYCLES(8)) u_lmef_top (.SYS_CLK, .RST_N, .SW, .CONFIG_MODE, .EEP_REQ,
        .RD_STN_VALID(stn_vld), .RD_STN_NUM(stn_num), .LOOPBACK_FAULT, .KEYS, .ARM_READY,
        .ARM_STORED, .ADDR, .WR_DATA, .WR_EN, .RD_EN, .RD_DATA, .IRQ, .SCREEN, .ARM_STORE,
        .SELFCHK_RUN);
    lmef_stn_model u_lmef_stn_model (.clk(SYS_CLK), .vld(stn_vld), .num(stn_num));
    initial begin
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    task automatic tick(int n);
        repeat (n) @(posedge SYS_CLK);
    endtask
    task automatic wr(logic [7:0] a, logic [15:0] d);
        @(posedge SYS_CLK);
        ADDR <= a;
        WR_DATA <= d;
        WR_EN <= 1'b1;
        @(posedge SYS_CLK);
        WR_EN <= 1'b0;
    endtask
    task automatic rdc(logic [7:0] a, logic [15:0] e);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD_EN <= 1'b1;
        @(posedge SYS_CLK);
        RD_EN <= 1'b0;
        #1;
        `CHK(RD_DATA, e)
    endtask
    task automatic key(logic [3:0] k);
        @(posedge SYS_CLK);
        KEYS <= k;
        @(posedge SYS_CLK);
        KEYS <= 4'h0;
        #1;
    endtask
    task automatic go_sc();
        repeat (3) key(4'h1);
        repeat (2) key(4'h2);
        key(4'h8);
    endtask
    task automatic pwr();
        @(posedge SYS_CLK);
        RST_N <= 1'b0;
        tick(12);
        RST_N <= 1'b1;
        tick(3);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        pwr();
        rdc(8'h00, 16'h0000);
        rdc(8'h12, 16'h0000);
        wr(8'h00, 16'hffff);
        rdc(8'h00, 16'h0000);
        wr(8'h08, 16'hffff);
        rdc(8'h08, 16'h003f);
        SW.rate <= 2'h3;
        tick(2);
        rdc(8'h00, 16'h0110);
        `CHK(IRQ, 1'b1)
        SW.rate <= 2'h0;
        tick(2);
        rdc(8'h00, 16'h0010);
        rdc(8'h04, 16'h0009);
        wr(8'h04, 16'h0009);
        wr(8'h08, 16'h0000);
        LOOPBACK_FAULT <= 1'b1;
        tick(1);
        LOOPBACK_FAULT <= 1'b0;
        tick(2);
        rdc(8'h00, 16'h8010);
        `CHK(IRQ, 1'b0)
        rdc(8'h04, 16'h0010);
        wr(8'h08, 16'h0010);
        #1;
        `CHK(IRQ, 1'b1)
        CONFIG_MODE <= 1'b1;
        EEP_REQ <= 1'b1;
        tick(2);
        rdc(8'h00, 16'h8010);
        CONFIG_MODE <= 1'b0;
        tick(2);
        rdc(8'h00, 16'h8090);
        CONFIG_MODE <= 1'b1;
        tick(2);
        rdc(8'h00, 16'h8090);
        EEP_REQ <= 1'b0;
        tick(2);
        rdc(8'h00, 16'h8010);
        key(4'h2);
        key(4'h8);
        `CHK(SCREEN, lmef_pkg::SCR_CONFIRM)
        for (int i = 0; i < 40 && SCREEN !== lmef_pkg::SCR_SETTINGS; i++) begin
            tick(1);
            #1;
        end
        `CHK(SCREEN, lmef_pkg::SCR_SETTINGS)
        if (error_cnt != 0) wrap_up();
        go_sc();
        key(4'h2);
        key(4'h1);
        `CHK(SCREEN, lmef_pkg::SCR_SC_START)
        key(4'h4);
        `CHK(SCREEN, lmef_pkg::SCR_SETTINGS)
        go_sc();
        key(4'h8);
        `CHK(SCREEN, lmef_pkg::SCR_SC_FAIL)
        key(4'h4);
        tick(1);
        ARM_READY <= 1'b1;
        go_sc();
        key(4'h8);
        `CHK(SCREEN, lmef_pkg::SCR_SC_DONE)
        tick(1);
        #1;
        `CHK({ARM_STORE, SELFCHK_RUN}, 2'h2)
        rdc(8'h04, 16'h0034);
        rdc(8'h0c, 16'h0034);
        tick(1);
        ARM_STORED <= 1'b1;
        pwr();
        #1;
        `CHK(SELFCHK_RUN, 1'b1)
        for (int i = 0; i < 5; i++) begin
            tick(1);
            SW.four_pt <= (i == 4);
            pwr();
            u_lmef_stn_model.attach(nums[i]);
            u_lmef_stn_model.detach();
            tick(2);
            rdc(8'h00, exps[i]);
        end
        tick(1);
        SW.four_pt <= 1'b0;
        pwr();
        rdc(8'h00, 16'h0000);
        wrap_up();
    end
endmodule
